// ==== rtl/opscfg_top.sv ====
`timescale 1ns/1ps
`include "opscfg_regs.svh"


module opscfg_top #(
  parameter int PAL_ENTRIES = 256
)
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IMG0_INTERLACED,
  output logic IMG1_INTERLACED,
  output logic [12:0] IN_WIDTH,
  output logic [12:0] IN_HEIGHT,
  input wire logic PIX_IMG_SEL,
  input wire logic [7:0] PIX_INDEX,
  output logic [23:0] PIX_RGB,
  output logic PIX_REMAP,
  input wire logic SUB1_VALID,
  input wire logic [23:0] SUB1_PIXEL,
  output logic SUB1_TRANSPARENT
);
  //****************************************************************
  // Register state
  //****************************************************************
  logic [1:0] scan_r;
  logic [1:0] scan_nxt;
  logic [24:0] key_r;
  logic [24:0] key_nxt;
  logic [11:0] width_r;
  logic [11:0] width_nxt;
  logic [11:0] height_r;
  logic [11:0] height_nxt;
  logic [10:0] mode_r;
  logic [10:0] mode_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic img0_il_r;
  logic img0_il_nxt;
  logic img1_il_r;
  logic img1_il_nxt;
  logic [12:0] width_out_r;
  logic [12:0] width_out_nxt;
  logic [12:0] height_out_r;
  logic [12:0] height_out_nxt;
  logic remap_r;
  logic remap_nxt;
  logic pal_hit;
  logic pal_wr;
  opscfg_pkg::opscfg_depth_type depth_sel;
  logic ycc_sel;

  //****************************************************************
  // Register writes
  //****************************************************************
  // Palette window decode
  always_comb
  begin
    pal_hit = (ADDR >= `OPSCFG_PAL_FIRST_OFS) && (ADDR <= `OPSCFG_PAL_LAST_OFS)
      && (ADDR[1:0] == 2'h0);
    pal_wr = WR && pal_hit;
  end

  // Next values of software registers; reserved bits dropped
  always_comb
  begin
    scan_nxt = scan_r;
    key_nxt = key_r;
    width_nxt = width_r;
    height_nxt = height_r;
    mode_nxt = mode_r;
    if (WR)
    begin
      unique case (ADDR)
        `OPSCFG_SCAN_FORMAT_OFS:
          scan_nxt = WDATA[`OPSCFG_IMG1_FMT_BIT:`OPSCFG_IMG0_FMT_BIT];
        `OPSCFG_SUB1_KEY_OFS:
          key_nxt = WDATA[`OPSCFG_KEY_EN_BIT:0];
        `OPSCFG_IN_WIDTH_OFS:
          width_nxt = WDATA[`OPSCFG_DIM_MSB:0];
        `OPSCFG_IN_HEIGHT_OFS:
          height_nxt = WDATA[`OPSCFG_DIM_MSB:0];
        `OPSCFG_MODE_CTRL_OFS:
          mode_nxt = WDATA[10:0];
        default:
          mode_nxt = mode_r;
      endcase
    end
  end

  //****************************************************************
  // Read path
  //****************************************************************
  // Read data for one cycle after a read strobe, else zero
  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (RD)
    begin
      unique case (ADDR)
        `OPSCFG_SCAN_FORMAT_OFS:
          rdata_nxt = {30'h00000000, scan_r};
        `OPSCFG_SUB1_KEY_OFS:
          rdata_nxt = {7'h00, key_r};
        `OPSCFG_IN_WIDTH_OFS:
          rdata_nxt = {20'h00000, width_r};
        `OPSCFG_IN_HEIGHT_OFS:
          rdata_nxt = {20'h00000, height_r};
        `OPSCFG_MODE_CTRL_OFS:
          rdata_nxt = {21'h000000, mode_r};
        default:
          rdata_nxt = 32'h00000000;
      endcase
    end
  end

  //****************************************************************
  // Derived settings for the pixel pipeline
  //****************************************************************
  // Scan format gated by ITU output enable, sizes plus one
  always_comb
  begin
    img0_il_nxt = mode_r[`OPSCFG_ITU_EN_BIT] && scan_r[0];
    img1_il_nxt = mode_r[`OPSCFG_ITU_EN_BIT] && scan_r[1];
    width_out_nxt = {1'b0, width_r} + 13'h0001;
    height_out_nxt = {1'b0, height_r} + 13'h0001;
  end

  // Palette applies only to indexed depths of RGB images
  always_comb
  begin
    if (PIX_IMG_SEL)
    begin
      depth_sel = opscfg_pkg::opscfg_depth_type'(mode_r[`OPSCFG_DEPTH1_LSB +: 3]);
      ycc_sel = mode_r[`OPSCFG_YCC1_BIT];
    end
    else
    begin
      depth_sel = opscfg_pkg::opscfg_depth_type'(mode_r[`OPSCFG_DEPTH0_LSB +: 3]);
      ycc_sel = mode_r[`OPSCFG_YCC0_BIT];
    end
    remap_nxt = !ycc_sel && (depth_sel <= opscfg_pkg::OPSCFG_BPP8);
  end

  //****************************************************************
  // Registers
  //****************************************************************
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      scan_r <= `OPSCFG_SCAN_RST;
      key_r <= `OPSCFG_KEY_RST;
      width_r <= `OPSCFG_DIM_RST;
      height_r <= `OPSCFG_DIM_RST;
      mode_r <= `OPSCFG_MODE_RST;
      rdata_r <= 32'h00000000;
      img0_il_r <= 1'b0;
      img1_il_r <= 1'b0;
      width_out_r <= 13'h0001;
      height_out_r <= 13'h0001;
      remap_r <= 1'b0;
    end
    else
    begin
      scan_r <= scan_nxt;
      key_r <= key_nxt;
      width_r <= width_nxt;
      height_r <= height_nxt;
      mode_r <= mode_nxt;
      rdata_r <= rdata_nxt;
      img0_il_r <= img0_il_nxt;
      img1_il_r <= img1_il_nxt;
      width_out_r <= width_out_nxt;
      height_out_r <= height_out_nxt;
      remap_r <= remap_nxt;
    end
  end

  //****************************************************************
  // Palette and colour key
  //****************************************************************
  opscfg_palette #(
    .ENTRIES(PAL_ENTRIES)
  )
  u_palette
  (
    .clk(CORE_CLK),
    .wr_en(pal_wr),
    .wr_pair(ADDR[8:2]),
    .wr_data(WDATA),
    .rd_index(PIX_INDEX),
    .rd_rgb(PIX_RGB)
  );

  opscfg_key u_key (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .key_en(key_r[`OPSCFG_KEY_EN_BIT]),
    .key_value(key_r[`OPSCFG_KEY_MSB:0]),
    .pix_valid(SUB1_VALID),
    .pix_value(SUB1_PIXEL),
    .transparent(SUB1_TRANSPARENT)
  );

  assign RDATA = rdata_r;
  assign IMG0_INTERLACED = img0_il_r;
  assign IMG1_INTERLACED = img1_il_r;
  assign IN_WIDTH = width_out_r;
  assign IN_HEIGHT = height_out_r;
  assign PIX_REMAP = remap_r;
endmodule

// ==== include/opscfg_regs.svh ====
`ifndef OPSCFG_REGS_SVH
`define OPSCFG_REGS_SVH

// Register byte offsets
`define OPSCFG_SCAN_FORMAT_OFS 16'h031C
`define OPSCFG_SUB1_KEY_OFS 16'h0320
`define OPSCFG_PAL_FIRST_OFS 16'h0A00
`define OPSCFG_PAL_LAST_OFS 16'h0BFC
`define OPSCFG_IN_WIDTH_OFS 16'h1100
`define OPSCFG_IN_HEIGHT_OFS 16'h1104
`define OPSCFG_MODE_CTRL_OFS 16'h1200

// Field positions
`define OPSCFG_IMG0_FMT_BIT 0
`define OPSCFG_IMG1_FMT_BIT 1
`define OPSCFG_KEY_EN_BIT 24
`define OPSCFG_KEY_MSB 23
`define OPSCFG_DIM_MSB 11
`define OPSCFG_ITU_EN_BIT 0
`define OPSCFG_YCC0_BIT 1
`define OPSCFG_YCC1_BIT 2
`define OPSCFG_DEPTH0_LSB 4
`define OPSCFG_DEPTH1_LSB 8

// Reset values
`define OPSCFG_SCAN_RST 2'h0
`define OPSCFG_KEY_RST 25'h0000000
`define OPSCFG_DIM_RST 12'h000
`define OPSCFG_MODE_RST 11'h000

`endif

// ==== include/opscfg_pkg.sv ====
package opscfg_pkg;
  // Bits per pixel codes of an image
  typedef enum logic [2:0]
  {
    OPSCFG_BPP1 = 3'h0,
    OPSCFG_BPP2 = 3'h1,
    OPSCFG_BPP4 = 3'h2,
    OPSCFG_BPP8 = 3'h3,
    OPSCFG_BPP16 = 3'h4,
    OPSCFG_BPP24 = 3'h5,
    OPSCFG_ARGB8888 = 3'h6,
    OPSCFG_ARGB1555 = 3'h7
  } opscfg_depth_type;
endpackage

// ==== rtl/opscfg_palette.sv ====
`timescale 1ns/1ps
`include "opscfg_regs.svh"

// Palette store: written as pairs, read per index with expansion
module opscfg_palette #(
  parameter int ENTRIES = 256
)
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(ENTRIES)-2:0] wr_pair,
  input wire logic [31:0] wr_data,
  input wire logic [$clog2(ENTRIES)-1:0] rd_index,
  output logic [23:0] rd_rgb
);
  logic [15:0] mem_r [0:ENTRIES-1];
  logic [15:0] entry;
  logic [23:0] rd_rgb_nxt;

  // Even entry from low half, odd from high half
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_r[{wr_pair, 1'b0}] <= wr_data[15:0];
      mem_r[{wr_pair, 1'b1}] <= wr_data[31:16];
    end
  end

  // Expand 565 to 888, zeros in low bits
  always_comb
  begin
    entry = mem_r[rd_index];
    rd_rgb_nxt = {entry[15:11], 3'h0, entry[10:5], 2'h0, entry[4:0], 3'h0};
  end

  // Registered colour output
  always_ff @(posedge clk)
  begin
    rd_rgb <= rd_rgb_nxt;
  end
endmodule

// ==== rtl/opscfg_key.sv ====
`timescale 1ns/1ps
`include "opscfg_regs.svh"

// Colour-key compare for sub-picture 1
module opscfg_key (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic key_en,
  input wire logic [23:0] key_value,
  input wire logic pix_valid,
  input wire logic [23:0] pix_value,
  output logic transparent
);
  logic transparent_nxt;

  // Exact match with key enabled marks pixel transparent
  always_comb
  begin
    transparent_nxt = key_en && pix_valid && (pix_value == key_value);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      transparent <= 1'b0;
    else
      transparent <= transparent_nxt;
  end
endmodule

// ==== bench/opscfg_props.sv ====
`timescale 1ns/1ps
// ****
// Port checker
// ****
module opscfg_props (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic IMG0_INTERLACED,
  input wire logic IMG1_INTERLACED,
  input wire logic [12:0] IN_WIDTH,
  input wire logic [12:0] IN_HEIGHT,
  input wire logic PIX_IMG_SEL,
  input wire logic PIX_REMAP,
  input wire logic SUB1_VALID,
  input wire logic [23:0] SUB1_PIXEL,
  input wire logic SUB1_TRANSPARENT
);
  logic [37:0] sh_r;
  logic [37:0] sh_nxt;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // Shadow of scan, key and mode registers
  always_comb
  begin
    sh_nxt = sh_r;
    if (WR && ADDR == 16'h031C) sh_nxt[1:0] = WDATA[1:0];
    if (WR && ADDR == 16'h0320) sh_nxt[26:2] = WDATA[24:0];
    if (WR && ADDR == 16'h1200) sh_nxt[37:27] = WDATA[10:0];
  end
  always_ff @(posedge CORE_CLK) sh_r <= RST_N ? sh_nxt : 38'h0;
  // Relations at the ports
  a_rdata_idle: assert property (RST_N && !RD |=> RDATA == 32'h0)
    else $error("read data not zero");
  a_palette_read: assert property (RD && ADDR[15:9] == 7'h05 |=> RDATA == 32'h0)
    else $error("palette read not zero");
  a_width_plus: assert property (WR && ADDR == 16'h1100 |-> ##2
    IN_WIDTH == {1'b0, $past(WDATA[11:0], 2)} + 13'h1)
    else $error("width wrong");
  a_height_plus: assert property (WR && ADDR == 16'h1104 |-> ##2
    IN_HEIGHT == {1'b0, $past(WDATA[11:0], 2)} + 13'h1)
    else $error("height wrong");
  a_scan_gate: assert property (RST_N |=> IMG0_INTERLACED == $past(sh_r[0] && sh_r[27])
    && IMG1_INTERLACED == $past(sh_r[1] && sh_r[27]))
    else $error("scan format wrong");
  a_key_match: assert property (RST_N && SUB1_VALID |=> SUB1_TRANSPARENT ==
    ($past(sh_r[26]) && $past(SUB1_PIXEL) == $past(sh_r[25:2])))
    else $error("key compare wrong");
  a_key_idle: assert property (RST_N && !SUB1_VALID |=> !SUB1_TRANSPARENT)
    else $error("key without pixel");
  a_remap_sel: assert property (RST_N |=> PIX_REMAP == $past(PIX_IMG_SEL ?
    !sh_r[29] && !sh_r[37] : !sh_r[28] && !sh_r[33]))
    else $error("remap wrong");
  c_key: cover property (SUB1_TRANSPARENT);
  c_interlace: cover property (IMG1_INTERLACED);
  c_remap_off: cover property (PIX_REMAP ##1 !PIX_REMAP);
endmodule

bind opscfg_top opscfg_props opscfg_props_inst (.*);

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
// ****
// Bench for the overlay configuration block
// ****
module tb_top;
  logic CORE_CLK = 0;
  logic RST_N = 0;
  logic [15:0] ADDR = 16'h0000;
  logic [31:0] WDATA = 32'h0;
  logic WR = 0;
  logic RD = 0;
  logic PIX_IMG_SEL = 0;
  logic [7:0] PIX_INDEX = 8'h00;
  logic SUB1_VALID = 0;
  logic [23:0] SUB1_PIXEL = 24'h0;
  logic [31:0] RDATA;
  logic IMG0_INTERLACED;
  logic IMG1_INTERLACED;
  logic [12:0] IN_WIDTH;
  logic [12:0] IN_HEIGHT;
  logic [23:0] PIX_RGB;
  logic PIX_REMAP;
  logic SUB1_TRANSPARENT;
  logic [11:0] sz [3] = '{12'h001, 12'h7FF, 12'h400};
  logic [15:0] pe [4] = '{16'hA5A5, 16'h5A5A, 16'h07E0, 16'hF81F};
  logic [7:0] pi [4] = '{8'h0A, 8'h0B, 8'hFE, 8'hFF};
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  opscfg_top opscfg_top_inst (.*);
  // Clock and run limit
  always #20 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // Register bus master
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    WR <= 1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CORE_CLK);
    WR <= 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge CORE_CLK);
    RD <= 1;
    ADDR <= a;
    @(posedge CORE_CLK);
    RD <= 0;
    #1 chk("rdata", e, RDATA);
  endtask
  task automatic settle;
    repeat (2) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic pix(input logic s, input logic [7:0] i, input logic v, input logic [23:0] p);
    @(posedge CORE_CLK);
    PIX_IMG_SEL <= s;
    PIX_INDEX <= i;
    SUB1_VALID <= v;
    SUB1_PIXEL <= p;
    @(posedge CORE_CLK);
    #1;
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge CORE_CLK);
    RST_N <= 1;
    settle();
    chk("width", 32'h1, 32'(IN_WIDTH));
    wr(16'h0400, 32'hFFFFFFFF);
    rd(16'h0400, 32'h0);
    foreach (sz[i])
    begin
      // Sizes stay in the legal range 1 to 2047
      wr(16'h1100, {20'hFFFFF, sz[i]});
      wr(16'h1104, {20'hFFFFF, 12'h800 - sz[i]});
      settle();
      chk("width", {20'h0, sz[i]} + 32'h1, 32'(IN_WIDTH));
      chk("height", {20'h0, 12'h800 - sz[i]} + 32'h1, 32'(IN_HEIGHT));
      rd(16'h1104, {20'h0, 12'h800 - sz[i]});
    end
    $display("test sizes done");
    wr(16'h031C, 32'hFFFFFFFF);
    rd(16'h031C, 32'h3);
    chk("img1", 32'h0, 32'(IMG1_INTERLACED));
    for (int s = 0; s < 4; s++)
    begin
      // ITU output enabled, each of the four scan format settings
      wr(16'h1200, 32'h1);
      wr(16'h031C, s);
      settle();
      chk("img0", s & 1, 32'(IMG0_INTERLACED));
      chk("img1", s >> 1, 32'(IMG1_INTERLACED));
    end
    $display("test scan done");
    wr(16'h0320, 32'hFFABCDEF);
    rd(16'h0320, 32'h01ABCDEF);
    pix(0, 8'h00, 1, 24'hABCDEF);
    chk("key", 32'h1, 32'(SUB1_TRANSPARENT));
    pix(0, 8'h00, 1, 24'hABCDEE);
    chk("key", 32'h0, 32'(SUB1_TRANSPARENT));
    wr(16'h0320, 32'h00ABCDEF);
    pix(0, 8'h00, 1, 24'hABCDEF);
    chk("key", 32'h0, 32'(SUB1_TRANSPARENT));
    $display("test key done");
    wr(16'h0A14, {pe[1], pe[0]});
    wr(16'h0BFC, {pe[3], pe[2]});
    rd(16'h0BFC, 32'h0);
    foreach (pe[i])
    begin
      pix(0, pi[i], 0, 24'h0);
      chk("rgb", {pe[i][15:11], 3'h0, pe[i][10:5], 2'h0, pe[i][4:0], 3'h0}, 32'(PIX_RGB));
    end
    for (int d = 0; d < 16; d++)
    begin
      wr(16'h1200, {21'h0, d[2:0] ^ 3'h4, 1'b0, d[2:0], 1'b0, ~d[3], d[3], 1'b1});
      pix(0, 8'h00, 0, 24'h0);
      chk("remap0", 32'(!d[3] && !d[2]), 32'(PIX_REMAP));
      pix(1, 8'h00, 0, 24'h0);
      chk("remap1", 32'(d[3] && d[2]), 32'(PIX_REMAP));
    end
    $display("test palette done");
    report_and_stop();
  end
endmodule
